// file: tb/tb.sv
`timescale 1ns/100ps
module tb;
  localparam logic [11:0] A_CA = tdi_pkg::ADDR_CFG_A, A_CB = tdi_pkg::ADDR_CFG_B, A_CT = tdi_pkg::ADDR_CTRL;
  localparam logic [11:0] A_ST = tdi_pkg::ADDR_STATUS, A_CL = tdi_pkg::ADDR_CLEAR, A_IE = tdi_pkg::ADDR_IRQEN;
  localparam logic [11:0] A_TH = tdi_pkg::ADDR_THR, A_TS = tdi_pkg::ADDR_TAPSRC;
  logic        clk, rstn, psel, pen, pwr, pready, perr, sample_rate_period, slp, int1, int2, irq, hsel, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] sx, sy, sz, hp;
  int          err_count = 0, num_checks = 0;
  tdi_top u_tdi_top
  (
    .i_clk(clk), .i_resetn(rstn), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(perr), .i_odr_tick(sample_rate_period),
    .i_slope_x(sx), .i_slope_y(sy), .i_slope_z(sz), .i_hpf_x(hp), .i_hpf_y(hp), .i_hpf_z(hp),
    .i_sleep_state(slp), .o_int1(int1), .o_int2(int2), .o_irq(irq), .o_wake_hpf_sel(hsel)
  );
  tdi_host u_tdi_host
  (
    .i_clk(clk), .i_prdata(prdata), .i_pready(pready), .i_pslverr(perr), .o_psel(psel),
    .o_penable(pen), .o_pwrite(pwr), .o_paddr(paddr), .o_pwdata(pwdata)
  );
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic chkb(input string n, input logic s, input logic x);
    chk(n, {31'h0, s}, {31'h0, x});
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_tdi_host.xfer(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a);
    u_tdi_host.xfer(1'b0, a, 32'h0, r, e);
  endtask
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  // One sample period boundary with the given magnitudes
  task automatic tick(input logic [15:0] x, y, z, h);
    @(posedge clk);
    {sx, sy, sz, hp} <= {x, y, z, h};
    sample_rate_period <= 1'b1;
    @(posedge clk);
    sample_rate_period <= 1'b0;
    #1;
  endtask
  task automatic t_regs;
    rd(A_CA);
    chk("cfg_a", r, 32'h0);
    rd(A_CB);
    chk("cfg_b", r, 32'h0);
    rd(12'hFFC);
    chkb("unmapped", e, 1'b1);
    wr(A_CA, 32'hFF);
    rd(A_CA);
    chk("cfg_a_rw", r, 32'h7F);
    chkb("hpf_sel", hsel, 1'b1);
    wr(A_CA, 32'h0);
  endtask
  task automatic t_evt;
    wr(A_TH, 32'h7C00);
    wr(A_CB, 32'h1E);
    wr(A_CA, 32'h08);
    tick(16'hF001, 16'h0, 16'h0, 16'h0);
    chkb("gen_off", int1, 1'b0);
    wr(A_CT, 32'h1);
    tick(16'hF000, 16'h0, 16'h0, 16'h0);
    chkb("at_thr", int1, 1'b0);
    tick(16'hF001, 16'h0, 16'h0, 16'h0);
    chkb("over_thr", int1, 1'b1);
    tick(16'h0, 16'hF001, 16'hF001, 16'h0);
    chkb("yz_off", int1, 1'b0);
  endtask
  task automatic t_pri;
    logic [1:0] top [8] = '{2'h0, 2'h1, 2'h0, 2'h2, 2'h0, 2'h1, 2'h2, 2'h2};
    wr(A_CA, 32'h0E);
    for (int i = 0; i < 8; i++)
    begin
      wr(A_CB, {24'h0, 3'(i), 5'h0});
      tick(16'h1, 16'h1, 16'h1, 16'h0);
      rd(A_TS);
      chk("top_axis", r, {30'h0, top[i]});
    end
  endtask
  task automatic t_latch;
    wr(A_CA, 32'h49);
    tick(16'hF001, 16'h0, 16'h0, 16'h0);
    tick(16'h0, 16'h0, 16'h0, 16'h0);
    chkb("held", int1, 1'b1);
    rd(A_ST);
    #1;
    chkb("read_rel", int1, 1'b0);
    wr(A_CA, 32'h09);
    tick(16'hF001, 16'h0, 16'h0, 16'h0);
    rd(A_ST);
    #1;
    chkb("odr_hold", int1, 1'b1);
    tick(16'h0, 16'h0, 16'h0, 16'h0);
    chkb("odr_rel", int1, 1'b0);
  endtask
  task automatic t_irq;
    wr(A_IE, 32'h1);
    step();
    chkb("irq_on", irq, 1'b1);
    wr(A_IE, 32'h0);
    step();
    chkb("irq_mask", irq, 1'b0);
    wr(A_IE, 32'h7);
    wr(A_CL, 32'h7);
    step();
    chkb("irq_clr", irq, 1'b0);
    rd(A_ST);
    chk("st_clr", r, 32'h0);
  endtask
  task automatic t_sleep;
    int n = 0;
    wr(A_CA, 32'h0);
    wr(A_CT, 32'h7);
    @(posedge clk);
    slp <= 1'b1;
    repeat (6)
    begin
      step();
      n += int'(int1 === 1'b1) + 8 * int'(int2 === 1'b1);
    end
    chk("pulses", 32'(n), 32'h9);
    wr(A_CA, 32'h20);
    repeat (2) step();
    chkb("lvl_hi", int1, 1'b1);
    @(posedge clk);
    slp <= 1'b0;
    repeat (3) step();
    chkb("lvl_lo", int2, 1'b0);
  endtask
  task automatic t_filt;
    wr(A_TH, 32'h0400);
    wr(A_CA, 32'h10);
    tick(16'h0801, 16'h0, 16'h0, 16'h0);
    rd(A_ST);
    chkb("slope_unsel", r[1], 1'b0);
    wr(A_CA, 32'h0);
    tick(16'h0801, 16'h0, 16'h0, 16'h0);
    rd(A_ST);
    chkb("slope_sel", r[1], 1'b1);
    wr(A_CL, 32'h2);
    wr(A_CA, 32'h10);
    tick(16'h0, 16'h0, 16'h0, 16'h0801);
    rd(A_ST);
    chkb("hpf_sel_wake", r[1], 1'b1);
  endtask
  task automatic print_verdict;
    if (err_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #500000;
    err_count++;
    print_verdict();
  end
  initial
  begin
    {rstn, sample_rate_period, slp, sx, sy, sz, hp} = '0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_evt();
    t_pri();
    t_latch();
    t_irq();
    t_sleep();
    t_filt();
    print_verdict();
  end
endmodule // tb

// file: tb/tdi_host.sv
`timescale 1ns/100ps
module tdi_host
(
  input  wire logic        i_clk,
  input  wire logic [31:0] i_prdata,
  input  wire logic        i_pready,
  input  wire logic        i_pslverr,
  output logic             o_psel,
  output logic             o_penable,
  output logic             o_pwrite,
  output logic      [11:0] o_paddr,
  output logic      [31:0] o_pwdata
);
  initial
  begin
    {o_psel, o_penable, o_pwrite, o_paddr, o_pwdata} = '0;
  end
  // Host keeps the reserved bit low and never asks for clear-on-read without latching
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rdata, output logic err);
    logic [31:0] d;
    d = (wr && a == tdi_pkg::ADDR_CFG_A) ? {24'h0, 1'b0, wd[6] & wd[0], wd[5:0]} : wd;
    @(posedge i_clk);
    {o_psel, o_pwrite, o_paddr, o_pwdata} <= {1'b1, wr, a, d};
    @(posedge i_clk);
    o_penable <= 1'b1;
    do
      @(posedge i_clk);
    while (i_pready !== 1'b1);
    {rdata, err} = {i_prdata, i_pslverr};
    {o_psel, o_penable} <= 2'b00;
  endtask
endmodule // tdi_host

// file: verilog/tdi_pkg.sv
package tdi_pkg;
  // ****************************************
  // Register map (index, byte address = 4 x index)
  // ****************************************
  localparam logic [9:0]  IDX_CFG_A  = 10'h056;
  localparam logic [9:0]  IDX_CFG_B  = 10'h057;
  localparam logic [9:0]  IDX_CTRL   = 10'h060;
  localparam logic [9:0]  IDX_STATUS = 10'h061;
  localparam logic [9:0]  IDX_CLEAR  = 10'h062;
  localparam logic [9:0]  IDX_IRQEN  = 10'h063;
  localparam logic [9:0]  IDX_THR    = 10'h064;
  localparam logic [9:0]  IDX_TAPSRC = 10'h065;
  localparam logic [11:0] ADDR_CFG_A  = {IDX_CFG_A, 2'h0};
  localparam logic [11:0] ADDR_CFG_B  = {IDX_CFG_B, 2'h0};
  localparam logic [11:0] ADDR_CTRL   = {IDX_CTRL, 2'h0};
  localparam logic [11:0] ADDR_STATUS = {IDX_STATUS, 2'h0};
  localparam logic [11:0] ADDR_CLEAR  = {IDX_CLEAR, 2'h0};
  localparam logic [11:0] ADDR_IRQEN  = {IDX_IRQEN, 2'h0};
  localparam logic [11:0] ADDR_THR    = {IDX_THR, 2'h0};
  localparam logic [11:0] ADDR_TAPSRC = {IDX_TAPSRC, 2'h0};
  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int CFGA_LIR = 0;
  localparam int CFGA_ZEN = 1;
  localparam int CFGA_YEN = 2;
  localparam int CFGA_XEN = 3;
  localparam int CFGA_FDS = 4;
  localparam int CFGA_SLP = 5;
  localparam int CFGA_COR = 6;
  localparam int CFGB_THR = 0;
  localparam int CFGB_PRI = 5;
  localparam int CTRL_GEN = 0;
  localparam int CTRL_P1  = 1;
  localparam int CTRL_P2  = 2;
  localparam int THR_Y    = 0;
  localparam int THR_Z    = 5;
  localparam int THR_WAKE = 10;
  localparam int EV_TAP   = 0;
  localparam int EV_WAKE  = 1;
  localparam int EV_SLEEP = 2;
  localparam int THR_SHIFT = 11;
  localparam logic [6:0]  CFG_A_RST = 7'h00;
  localparam logic [7:0]  CFG_B_RST = 8'h00;
  localparam logic [2:0]  CTRL_RST  = 3'h0;
  localparam logic [14:0] THR_RST   = 15'h0000;
  localparam logic [2:0]  IRQEN_RST = 3'h0;
  localparam logic [1:0]  AX_X = 2'h0;
  localparam logic [1:0]  AX_Y = 2'h1;
  localparam logic [1:0]  AX_Z = 2'h2;
  // Rank per priority code: {max, mid, min}
  localparam logic [5:0] RANK [0:7] = '{6'h06, 6'h12, 6'h09, 6'h24, 6'h06, 6'h18, 6'h21, 6'h24};
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic {ST_IDLE = 1'b0, ST_RESP = 1'b1} tdi_apb_e;
  typedef struct packed {
    tdi_apb_e    st;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [6:0]  cfg_a;
    logic [7:0]  cfg_b;
    logic [2:0]  ctrl;
    logic [14:0] thr;
    logic [2:0]  irq_en;
    logic [2:0]  status;
    logic [1:0]  tap_axis;
    logic [2:0]  req;
    logic [2:0]  pend;
    logic        sleep_q;
    logic        int1;
    logic        int2;
    logic        irq;
  } tdi_state_s;
endpackage

// file: verilog/tdi_top.sv
`timescale 1ns/100ps
module tdi_top
(
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_odr_tick,
  input  wire logic [15:0] i_slope_x,
  input  wire logic [15:0] i_slope_y,
  input  wire logic [15:0] i_slope_z,
  input  wire logic [15:0] i_hpf_x,
  input  wire logic [15:0] i_hpf_y,
  input  wire logic [15:0] i_hpf_z,
  input  wire logic        i_sleep_state,
  output logic             o_int1,
  output logic             o_int2,
  output logic             o_irq,
  output logic             o_wake_hpf_sel
);
  // ****************************************
  // Per-axis qualification
  // ****************************************
  tdi_pkg::tdi_state_s state_ff;
  tdi_pkg::tdi_state_s nxt_state;
  logic [2:0][15:0] slope_m;
  logic [2:0][15:0] hpf_m;
  logic [2:0][4:0]  tap_thr;
  logic [2:0]       axis_en;
  logic [2:0]       over_tap;
  logic [2:0]       over_wake;
  logic [2:0][15:0] tap_lim;
  logic [15:0]      wake_lim;
  logic [2:0]       ev;
  logic [1:0]       sel_axis;
  logic [5:0]       rank;
  logic [31:0]      rd_val;
  logic             hit;
  logic             acc;
  logic             done;
  logic             status_rd;
  logic             wr_any;
  logic [2:0]       clr;
  logic             gen;
  logic             latch_irq_requests;
  logic             cor;
  logic             sleep_sig;

  assign slope_m = {i_slope_z, i_slope_y, i_slope_x};
  assign hpf_m   = {i_hpf_z, i_hpf_y, i_hpf_x};
  assign tap_thr = {state_ff.thr[tdi_pkg::THR_Z +: 5], state_ff.thr[tdi_pkg::THR_Y +: 5],
                    state_ff.cfg_b[tdi_pkg::CFGB_THR +: 5]};
  assign axis_en = {state_ff.cfg_a[tdi_pkg::CFGA_ZEN], state_ff.cfg_a[tdi_pkg::CFGA_YEN],
                    state_ff.cfg_a[tdi_pkg::CFGA_XEN]};
  assign gen = state_ff.ctrl[tdi_pkg::CTRL_GEN];
  assign latch_irq_requests = state_ff.cfg_a[tdi_pkg::CFGA_LIR];
  assign cor = state_ff.cfg_a[tdi_pkg::CFGA_COR];
  // Threshold LSB is full scale / 32
  assign wake_lim = 16'(state_ff.thr[tdi_pkg::THR_WAKE +: 5]) << tdi_pkg::THR_SHIFT;

  genvar ax;
  generate
    for (ax = 0; ax < 3; ax++)
    begin : g_axis
      assign tap_lim[ax]   = 16'(tap_thr[ax]) << tdi_pkg::THR_SHIFT;
      assign over_tap[ax]  = axis_en[ax] && (slope_m[ax] > tap_lim[ax]);
      assign over_wake[ax] = state_ff.cfg_a[tdi_pkg::CFGA_FDS] ? (hpf_m[ax] > wake_lim) :
                             (slope_m[ax] > wake_lim);
    end
  endgenerate

  // ****************************************
  // Tap axis ranking
  // ****************************************
  always_comb
  begin
    rank     = tdi_pkg::RANK[state_ff.cfg_b[tdi_pkg::CFGB_PRI +: 3]];
    sel_axis = tdi_pkg::AX_X;
    // Lowest rank first, highest qualifying rank wins
    for (int k = 0; k < 3; k++)
    begin
      if (over_tap[rank[2*k +: 2]])
      begin
        sel_axis = rank[2*k +: 2];
      end
    end
  end

  // Basic events gated by global enable
  assign ev[tdi_pkg::EV_TAP]   = i_odr_tick && gen && (|over_tap);
  assign ev[tdi_pkg::EV_WAKE]  = i_odr_tick && gen && (|over_wake);
  assign ev[tdi_pkg::EV_SLEEP] = gen && (i_sleep_state != state_ff.sleep_q);

  // ****************************************
  // APB decode
  // ****************************************
  assign acc       = i_psel && i_penable;
  assign done      = acc && (state_ff.st == tdi_pkg::ST_RESP);
  assign status_rd = done && !i_pwrite && (i_paddr == tdi_pkg::ADDR_STATUS);
  assign wr_any    = done && i_pwrite;

  always_comb
  begin
    hit    = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (i_paddr)
      tdi_pkg::ADDR_CFG_A:  rd_val[6:0]  = state_ff.cfg_a;
      tdi_pkg::ADDR_CFG_B:  rd_val[7:0]  = state_ff.cfg_b;
      tdi_pkg::ADDR_CTRL:   rd_val[2:0]  = state_ff.ctrl;
      tdi_pkg::ADDR_STATUS: rd_val[2:0]  = state_ff.status;
      tdi_pkg::ADDR_CLEAR:  rd_val       = 32'h0000_0000;
      tdi_pkg::ADDR_IRQEN:  rd_val[2:0]  = state_ff.irq_en;
      tdi_pkg::ADDR_THR:    rd_val[14:0] = state_ff.thr;
      tdi_pkg::ADDR_TAPSRC: rd_val[1:0]  = state_ff.tap_axis;
      default:              hit          = 1'b0;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    nxt_state = state_ff;
    clr       = 3'h0;
    unique case (state_ff.st)
      tdi_pkg::ST_IDLE:
      begin
        if (acc)
        begin
          nxt_state.st      = tdi_pkg::ST_RESP;
          nxt_state.pready  = 1'b1;
          nxt_state.prdata  = rd_val;
          nxt_state.pslverr = !hit;
        end
      end
      tdi_pkg::ST_RESP:
      begin
        nxt_state.st      = tdi_pkg::ST_IDLE;
        nxt_state.pready  = 1'b0;
        nxt_state.pslverr = 1'b0;
        nxt_state.prdata  = 32'h0000_0000;
        if (wr_any)
        begin
          unique case (i_paddr)
            tdi_pkg::ADDR_CFG_A: nxt_state.cfg_a  = i_pwdata[6:0];
            tdi_pkg::ADDR_CFG_B: nxt_state.cfg_b  = i_pwdata[7:0];
            tdi_pkg::ADDR_CTRL:  nxt_state.ctrl   = i_pwdata[2:0];
            tdi_pkg::ADDR_CLEAR: clr              = i_pwdata[2:0];
            tdi_pkg::ADDR_IRQEN: nxt_state.irq_en = i_pwdata[2:0];
            tdi_pkg::ADDR_THR:   nxt_state.thr    = i_pwdata[14:0];
            default:             clr              = 3'h0;
          endcase
        end
      end
    endcase

    // Sticky status, set wins over clear
    nxt_state.status  = (state_ff.status & ~clr) | ev;
    nxt_state.sleep_q = i_sleep_state;
    if (ev[tdi_pkg::EV_TAP])
    begin
      nxt_state.tap_axis = sel_axis;
    end

    // Pin requests
    for (int i = 0; i < 3; i++)
    begin
      if (latch_irq_requests)
      begin
        if (status_rd && cor)
        begin
          nxt_state.req[i] = 1'b0;
        end
        if (i_odr_tick && state_ff.pend[i])
        begin
          nxt_state.req[i]  = 1'b0;
          nxt_state.pend[i] = 1'b0;
        end
        if (status_rd && !cor && state_ff.req[i])
        begin
          nxt_state.pend[i] = 1'b1;
        end
        if (ev[i])
        begin
          nxt_state.req[i]  = 1'b1;
          nxt_state.pend[i] = 1'b0;
        end
      end
      else
      begin
        nxt_state.pend[i] = 1'b0;
        if (i_odr_tick || (i == tdi_pkg::EV_SLEEP))
        begin
          nxt_state.req[i] = ev[i];
        end
      end
    end

    sleep_sig = state_ff.cfg_a[tdi_pkg::CFGA_SLP] ? nxt_state.sleep_q :
                nxt_state.req[tdi_pkg::EV_SLEEP];
    nxt_state.int1 = nxt_state.req[tdi_pkg::EV_TAP] || nxt_state.req[tdi_pkg::EV_WAKE] ||
                     (state_ff.ctrl[tdi_pkg::CTRL_P1] && sleep_sig);
    nxt_state.int2 = state_ff.ctrl[tdi_pkg::CTRL_P2] && sleep_sig;
    nxt_state.irq  = |(nxt_state.status & nxt_state.irq_en);
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      state_ff        <= '0;
      state_ff.st     <= tdi_pkg::ST_IDLE;
      state_ff.cfg_a  <= tdi_pkg::CFG_A_RST;
      state_ff.cfg_b  <= tdi_pkg::CFG_B_RST;
      state_ff.ctrl   <= tdi_pkg::CTRL_RST;
      state_ff.thr    <= tdi_pkg::THR_RST;
      state_ff.irq_en <= tdi_pkg::IRQEN_RST;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign o_prdata       = state_ff.prdata;
  assign o_pready       = state_ff.pready;
  assign o_pslverr      = state_ff.pslverr;
  assign o_int1         = state_ff.int1;
  assign o_int2         = state_ff.int2;
  assign o_irq          = state_ff.irq;
  assign o_wake_hpf_sel = state_ff.cfg_a[tdi_pkg::CFGA_FDS];

  // ****************************************
  // Assertions
  // ****************************************
  latch_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (latch_irq_requests && state_ff.req[tdi_pkg::EV_TAP] && !state_ff.pend[tdi_pkg::EV_TAP] && !status_rd && !wr_any)
    |=> state_ff.req[tdi_pkg::EV_TAP])
    else $error("latched tap request dropped");

  clr_read_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (status_rd && latch_irq_requests && cor && !ev[tdi_pkg::EV_TAP]) |=> !state_ff.req[tdi_pkg::EV_TAP])
    else $error("clear on read did not release request");

  clr_period_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (latch_irq_requests && !cor && !wr_any && status_rd && state_ff.req[tdi_pkg::EV_TAP] && !ev[tdi_pkg::EV_TAP] &&
     !(i_odr_tick && state_ff.pend[tdi_pkg::EV_TAP]))
    |=> (state_ff.req[tdi_pkg::EV_TAP] && state_ff.pend[tdi_pkg::EV_TAP]))
    else $error("request released before period end");

  tap_follow_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (!latch_irq_requests && i_odr_tick) |=> (state_ff.req[tdi_pkg::EV_TAP] == $past(ev[tdi_pkg::EV_TAP])))
    else $error("unlatched tap request not following event");

  sleep_level_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (state_ff.cfg_a[tdi_pkg::CFGA_SLP] && state_ff.ctrl[tdi_pkg::CTRL_P2] && !wr_any)
    |=> (o_int2 == $past(i_sleep_state)))
    else $error("pin 2 not showing sleep level");

  filter_sel_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_odr_tick && gen && state_ff.cfg_a[tdi_pkg::CFGA_FDS] &&
     (i_hpf_y > (16'(state_ff.thr[tdi_pkg::THR_WAKE +: 5]) << tdi_pkg::THR_SHIFT)))
    |=> state_ff.status[tdi_pkg::EV_WAKE])
    else $error("high-pass wake event missed");

  axis_off_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (axis_en == 3'h0) |=> !$rose(state_ff.status[tdi_pkg::EV_TAP]))
    else $error("tap with all axes disabled");

  thr_x_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_odr_tick && gen && (axis_en == 3'h1) &&
     (i_slope_x > (16'(state_ff.cfg_b[tdi_pkg::CFGB_THR +: 5]) << tdi_pkg::THR_SHIFT)))
    |=> (state_ff.status[tdi_pkg::EV_TAP] && (state_ff.tap_axis == tdi_pkg::AX_X)))
    else $error("X tap over threshold missed");

  prio_rank_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (ev[tdi_pkg::EV_TAP] && (over_tap == 3'h7) && (state_ff.cfg_b[tdi_pkg::CFGB_PRI +: 3] == 3'h5))
    |=> (state_ff.tap_axis == tdi_pkg::AX_Y))
    else $error("wrong tap axis for priority 5");

  gen_gate_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !gen |=> (!$rose(state_ff.status[tdi_pkg::EV_TAP]) && !$rose(state_ff.status[tdi_pkg::EV_WAKE])))
    else $error("event while interrupts disabled");

  apb_answer_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (acc && (state_ff.st == tdi_pkg::ST_IDLE)) |=> o_pready ##1 !o_pready)
    else $error("APB answer not one cycle after access");
endmodule // tdi_top
